// file: rtl/pesb_top.sv
// Event-select, qualification and counter for branch and stall events, with an AXI4-Lite register port.
// Assumes pipeline strobes are synchronous to I_CLK and valid for one cycle each.
`timescale 1ns/1ns
// Summary of operation
// (R1) Executed-branch not-taken bit counts only conditional branches that were not taken.
// (R2) Software pairs the taken bit with at least one branch-type bit.
// (R3) Unit-mask all-ones counts every executed near branch, retired or not.
// (R4) Software pairs mispredicted conditional type with a taken or not-taken bit.
// (R5) Software pairs mispredicted non-conditional types with the taken bit.
// (R6) Mispredicted not-taken bit applies only to conditional branches.
// (R7) Mispredicted taken bit qualifies taken branches of the selected types.
// (R8) Front-end event counts empty issue slots while back end is not stalled.
// (R9) Port dispatch event counts cycles with a micro-op on a selected port.
// (R10) Resource-stall any counts every allocation stall cycle.
// (R11) Scheduler-entry stall counts cycles with no eligible scheduler entry.
// (R12) Store-buffer stall counts cycles without free store buffer, excluding sync drain.
// (R13) Reorder-buffer stall counts cycles with the reorder buffer full.
// (R14) Pending-load event counts L2-miss cycles; all-threads makes it per core.
// (R15) A nonzero threshold counts once per cycle meeting it, not by occurrences.
// (R16) Edge detect counts only transitions into the event condition.
// (R17) Counter advances only on code match with a true unit-mask condition.
// (R18) Combined branch masks need both type and direction bits selected.
module pesb_top #(
	parameter int CNT_W = 32
) (
	// Clock and reset
	input  wire logic                          I_CLK,
	input  wire logic                          I_RST_B,
	// AXI4-Lite write address and data
	input  wire logic                          I_AWVALID,
	output logic                               O_AWREADY,
	input  wire logic [7:0]                    I_AWADDR,
	input  wire logic                          I_WVALID,
	output logic                               O_WREADY,
	input  wire logic [31:0]                   I_WDATA,
	input  wire logic [3:0]                    I_WSTRB,
	// AXI4-Lite write response
	output logic                               O_BVALID,
	input  wire logic                          I_BREADY,
	output logic      [1:0]                    O_BRESP,
	// AXI4-Lite read
	input  wire logic                          I_ARVALID,
	output logic                               O_ARREADY,
	input  wire logic [7:0]                    I_ARADDR,
	output logic                               O_RVALID,
	input  wire logic                          I_RREADY,
	output logic      [31:0]                   O_RDATA,
	output logic      [1:0]                    O_RRESP,
	// Branch execution strobes
	input  wire logic                          I_BR_VALID,
	input  wire logic [pesb_pkg::BR_TYPES-1:0] I_BR_TYPE,
	input  wire logic                          I_BR_TAKEN,
	input  wire logic                          I_BR_MISP,
	// Front end and dispatch
	input  wire logic [pesb_pkg::INC_W-1:0]    I_FE_EMPTY_SLOTS,
	input  wire logic                          I_BE_STALL,
	input  wire logic [pesb_pkg::PORTS-1:0]    I_PORT_DISP,
	// Allocation stalls
	input  wire logic                          I_STALL_ANY,
	input  wire logic                          I_STALL_SCHED,
	input  wire logic                          I_STALL_STORE_BUF,
	input  wire logic                          I_STALL_STORE_DRAIN,
	input  wire logic                          I_STALL_ROB,
	// Pending L2-miss loads
	input  wire logic                          I_L2_PEND_THREAD,
	input  wire logic                          I_L2_PEND_OTHER,
	// Counter status
	output logic      [CNT_W-1:0]              O_COUNT,
	output logic                               O_OVERFLOW
);
	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				res[b*8 +: 8] = nw[b*8 +: 8];
		end
		return res;
	endfunction

	// Word offsets only; any other address answers with an error
	function automatic logic addr_mapped(input logic [7:0] a);
		return a == pesb_pkg::ADDR_SELECT || a == pesb_pkg::ADDR_COUNT || a == pesb_pkg::ADDR_STATUS;
	endfunction

	// Select register and counter state
	logic [31:0]                  sel;
	logic [31:0]                  next_sel;
	logic [CNT_W-1:0]             next_count;
	logic                         next_overflow;
	logic                         prev_cond;
	logic                         next_prev_cond;

	// Write channel state
	logic                         aw_held;
	logic                         next_aw_held;
	logic                         w_held;
	logic                         next_w_held;
	logic [7:0]                   waddr;
	logic [7:0]                   next_waddr;
	logic [31:0]                  wdata;
	logic [31:0]                  next_wdata;
	logic [3:0]                   wstrb;
	logic [3:0]                   next_wstrb;
	logic                         next_awready;
	logic                         next_wready;
	logic                         next_bvalid;
	logic [1:0]                   next_bresp;
	// Read channel state
	logic                         next_arready;
	logic                         next_rvalid;
	logic [31:0]                  next_rdata;
	logic [1:0]                   next_rresp;

	// Event path
	logic [pesb_pkg::INC_W-1:0]   raw;
	logic [7:0]                   cmask;
	logic                         cond;
	logic [pesb_pkg::INC_W-1:0]   inc;
	logic [CNT_W:0]               sum;
	logic                         commit;

	pesb_event_decode u_decode (
		.i_code              (sel[pesb_pkg::SEL_CODE_LSB +: 8]),
		.i_umask             (sel[pesb_pkg::SEL_UMASK_LSB +: 8]),
		.i_all_threads       (sel[pesb_pkg::SEL_ALL_THREADS]),
		.i_br_valid          (I_BR_VALID),
		.i_br_type           (I_BR_TYPE),
		.i_br_taken          (I_BR_TAKEN),
		.i_br_misp           (I_BR_MISP),
		.i_fe_empty_slots    (I_FE_EMPTY_SLOTS),
		.i_be_stall          (I_BE_STALL),
		.i_port_disp         (I_PORT_DISP),
		.i_stall_any         (I_STALL_ANY),
		.i_stall_sched       (I_STALL_SCHED),
		.i_stall_store_buf   (I_STALL_STORE_BUF),
		.i_stall_store_drain (I_STALL_STORE_DRAIN),
		.i_stall_rob         (I_STALL_ROB),
		.i_l2_pend_thread    (I_L2_PEND_THREAD),
		.i_l2_pend_other     (I_L2_PEND_OTHER),
		.o_raw               (raw)
	);

	// Qualification: threshold then edge
	always_comb begin
		cmask = sel[pesb_pkg::SEL_CMASK_LSB +: 8];
		if (cmask == 8'h00) begin
			cond = (raw != '0);
			inc  = raw;
		end else begin
			// Compared against this cycle's occurrences, not the running total
			cond = ({5'h00, raw} >= cmask); // [R15]
			inc  = {{(pesb_pkg::INC_W-1){1'b0}}, cond}; // [R15]
		end
		if (sel[pesb_pkg::SEL_EDGE])
			inc = {{(pesb_pkg::INC_W-1){1'b0}}, cond & ~prev_cond}; // [R16]
		if (!sel[pesb_pkg::SEL_ENABLE])
			inc = '0;
		next_prev_cond = cond;
	end

	// Bus channel bookkeeping
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_waddr   = waddr;
		next_wdata   = wdata;
		next_wstrb   = wstrb;
		next_bvalid  = O_BVALID;
		next_bresp   = O_BRESP;
		commit       = 1'b0;
		// Address and data may land in either order
		if (I_AWVALID && O_AWREADY) begin
			next_aw_held = 1'b1;
			next_waddr   = I_AWADDR;
		end
		if (I_WVALID && O_WREADY) begin
			next_w_held = 1'b1;
			next_wdata  = I_WDATA;
			next_wstrb  = I_WSTRB;
		end
		if (O_BVALID && I_BREADY)
			next_bvalid = 1'b0;
		// Write commits in the cycle both halves are held, once no response is pending
		if (aw_held && w_held && !O_BVALID) begin
			commit       = 1'b1;
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			if (addr_mapped(waddr))
				next_bresp = pesb_pkg::RESP_OKAY;
			else
				next_bresp = pesb_pkg::RESP_SLVERR;
		end
		// Ready only while nothing of that kind is held or answering
		next_awready = ~next_aw_held & ~next_bvalid;
		next_wready  = ~next_w_held & ~next_bvalid;
	end

	// Read channel; the count is captured when the address is taken
	always_comb begin
		next_rvalid  = O_RVALID;
		next_rdata   = O_RDATA;
		next_rresp   = O_RRESP;
		if (O_RVALID && I_RREADY)
			next_rvalid = 1'b0;
		if (I_ARVALID && O_ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp  = pesb_pkg::RESP_OKAY;
			unique case (I_ARADDR)
				pesb_pkg::ADDR_SELECT: next_rdata = sel;
				pesb_pkg::ADDR_COUNT:  next_rdata = 32'(O_COUNT);
				pesb_pkg::ADDR_STATUS: next_rdata = {30'h0, prev_cond, O_OVERFLOW};
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = pesb_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_arready = ~next_rvalid;
	end

	// Select register, counter and overflow flag
	always_comb begin
		next_sel      = sel;
		sum           = {1'b0, O_COUNT} + {{(CNT_W+1-pesb_pkg::INC_W){1'b0}}, inc}; // [R17]
		next_count    = sum[CNT_W-1:0];
		next_overflow = O_OVERFLOW;
		// Unused select bits are dropped so they read back as zero
		if (commit && waddr == pesb_pkg::ADDR_SELECT)
			next_sel = merge_strb(sel, wdata, wstrb) & pesb_pkg::SEL_WMASK;
		// Software preset takes priority over a counted event
		if (commit && waddr == pesb_pkg::ADDR_COUNT)
			next_count = CNT_W'(merge_strb(32'(O_COUNT), wdata, wstrb));
		// Write-one clear; a same-cycle wrap keeps the flag set
		if (commit && waddr == pesb_pkg::ADDR_STATUS && wstrb[0] && wdata[pesb_pkg::ST_OVERFLOW])
			next_overflow = 1'b0;
		// Carry out of the counter sets the sticky flag
		if (sum[CNT_W] && !(commit && waddr == pesb_pkg::ADDR_COUNT))
			next_overflow = 1'b1;
	end

	// Edge history runs while disabled, so enabling mid-event counts no edge
	always_ff @(posedge I_CLK) begin
		if (!I_RST_B)
			prev_cond <= 1'b0;
		else
			prev_cond <= next_prev_cond;
	end

	// Ready is low in reset, so nothing is taken before the first edge after release
	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			aw_held    <= 1'b0;
			w_held     <= 1'b0;
			waddr      <= 8'h00;
			wdata      <= 32'h0000_0000;
			wstrb      <= 4'h0;
			O_AWREADY  <= 1'b0;
			O_WREADY   <= 1'b0;
			O_BVALID   <= 1'b0;
			O_BRESP    <= pesb_pkg::RESP_OKAY;
		end else begin
			aw_held    <= next_aw_held;
			w_held     <= next_w_held;
			waddr      <= next_waddr;
			wdata      <= next_wdata;
			wstrb      <= next_wstrb;
			O_AWREADY  <= next_awready;
			O_WREADY   <= next_wready;
			O_BVALID   <= next_bvalid;
			O_BRESP    <= next_bresp;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			O_ARREADY  <= 1'b0;
			O_RVALID   <= 1'b0;
			O_RDATA    <= 32'h0000_0000;
			O_RRESP    <= pesb_pkg::RESP_OKAY;
		end else begin
			O_ARREADY  <= next_arready;
			O_RVALID   <= next_rvalid;
			O_RDATA    <= next_rdata;
			O_RRESP    <= next_rresp;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			sel        <= pesb_pkg::SEL_RESET;
			O_COUNT    <= '0;
			O_OVERFLOW <= 1'b0;
		end else begin
			sel        <= next_sel;
			O_COUNT    <= next_count;
			O_OVERFLOW <= next_overflow;
		end
	end
endmodule

// file: rtl/pesb_event_decode.sv
// Shared constants and the per-cycle event decoder for the branch/stall counter.
// Assumes all event strobes come from core logic on the same clock.
package pesb_pkg;
	localparam logic [7:0] EV_BRANCH_EXEC  = 8'h88;
	localparam logic [7:0] EV_BRANCH_MISP  = 8'h89;
	localparam logic [7:0] EV_FE_UNDELIV   = 8'h9c;
	localparam logic [7:0] EV_PORT_DISP    = 8'ha1;
	localparam logic [7:0] EV_RES_STALL    = 8'ha2;
	localparam logic [7:0] EV_PEND_LOAD    = 8'ha3;
	localparam logic [7:0] UM_ALL          = 8'hff;
	localparam logic [7:0] UM_FE_CORE      = 8'h01;
	localparam logic [7:0] UM_STALL_ANY    = 8'h01;
	localparam logic [7:0] UM_STALL_SCHED  = 8'h04;
	localparam logic [7:0] UM_STALL_SB     = 8'h08;
	localparam logic [7:0] UM_STALL_ROB    = 8'h10;
	localparam logic [7:0] UM_PEND_L2      = 8'h01;
	localparam logic [7:0] UM_PORT0        = 8'h01;
	localparam logic [7:0] UM_PORT1        = 8'h02;
	localparam logic [7:0] UM_PORT2        = 8'h0c;
	localparam logic [7:0] UM_PORT3        = 8'h30;
	localparam logic [7:0] UM_PORT4        = 8'h40;
	localparam logic [7:0] UM_PORT5        = 8'h80;
	localparam int         UM_NOT_TAKEN    = 6;
	localparam int         UM_TAKEN        = 7;
	localparam int         BR_TYPES        = 6;
	localparam int         BR_COND         = 0;
	localparam int         PORTS           = 6;
	localparam int         INC_W           = 3;
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_SELECT     = 8'h00;
	localparam logic [7:0] ADDR_COUNT      = 8'h04;
	localparam logic [7:0] ADDR_STATUS     = 8'h08;
	// Select register fields
	localparam int         SEL_CODE_LSB    = 0;
	localparam int         SEL_UMASK_LSB   = 8;
	localparam int         SEL_EDGE        = 18;
	localparam int         SEL_ALL_THREADS = 21;
	localparam int         SEL_ENABLE      = 22;
	localparam int         SEL_CMASK_LSB   = 24;
	localparam logic [31:0] SEL_RESET      = 32'h0000_0000;
	localparam logic [31:0] SEL_WMASK      = 32'hff64_ffff;
	localparam int         ST_OVERFLOW     = 0;
	localparam int         ST_ACTIVE       = 1;
	localparam logic [1:0] RESP_OKAY       = 2'b00;
	localparam logic [1:0] RESP_SLVERR     = 2'b10;
endpackage

`timescale 1ns/1ns
module pesb_event_decode (
	// Selection
	input  wire logic [7:0]                  i_code,
	input  wire logic [7:0]                  i_umask,
	input  wire logic                        i_all_threads,
	// Branch execution strobe
	input  wire logic                        i_br_valid,
	input  wire logic [pesb_pkg::BR_TYPES-1:0] i_br_type,
	input  wire logic                        i_br_taken,
	input  wire logic                        i_br_misp,
	// Front end, dispatch, stalls, loads
	input  wire logic [pesb_pkg::INC_W-1:0]  i_fe_empty_slots,
	input  wire logic                        i_be_stall,
	input  wire logic [pesb_pkg::PORTS-1:0]  i_port_disp,
	input  wire logic                        i_stall_any,
	input  wire logic                        i_stall_sched,
	input  wire logic                        i_stall_store_buf,
	input  wire logic                        i_stall_store_drain,
	input  wire logic                        i_stall_rob,
	input  wire logic                        i_l2_pend_thread,
	input  wire logic                        i_l2_pend_other,
	// Occurrences this cycle
	output logic      [pesb_pkg::INC_W-1:0]  o_raw
);
	function automatic logic branch_hit(input logic [7:0] um, input logic [pesb_pkg::BR_TYPES-1:0] ty,
		input logic tk);
		logic type_sel;
		logic dir_sel;
		type_sel = |(ty & um[pesb_pkg::BR_TYPES-1:0]);
		// Not-taken only qualifies conditional branches
		dir_sel  = (um[pesb_pkg::UM_TAKEN] & tk) | // [R7]
			(um[pesb_pkg::UM_NOT_TAKEN] & ~tk & ty[pesb_pkg::BR_COND]); // [R1] [R6]
		if (um == pesb_pkg::UM_ALL)
			return 1'b1; // [R3]
		return type_sel & dir_sel; // [R18] [R2] [R4] [R5]
	endfunction

	logic hit;
	logic [pesb_pkg::INC_W-1:0] one;
	assign one = {{(pesb_pkg::INC_W-1){1'b0}}, 1'b1};

	always_comb begin
		hit   = 1'b0;
		o_raw = '0;
		unique case (i_code)
			pesb_pkg::EV_BRANCH_EXEC:
				hit = i_br_valid & branch_hit(i_umask, i_br_type, i_br_taken);
			pesb_pkg::EV_BRANCH_MISP:
				hit = i_br_valid & i_br_misp & branch_hit(i_umask, i_br_type, i_br_taken);
			pesb_pkg::EV_FE_UNDELIV:
				if (i_umask == pesb_pkg::UM_FE_CORE && !i_be_stall)
					o_raw = i_fe_empty_slots; // [R8]
			pesb_pkg::EV_PORT_DISP: begin
				hit = (|(i_umask & pesb_pkg::UM_PORT0) & i_port_disp[0]) // [R9]
					| (|(i_umask & pesb_pkg::UM_PORT1) & i_port_disp[1])
					| (|(i_umask & pesb_pkg::UM_PORT2) & i_port_disp[2])
					| (|(i_umask & pesb_pkg::UM_PORT3) & i_port_disp[3])
					| (|(i_umask & pesb_pkg::UM_PORT4) & i_port_disp[4])
					| (|(i_umask & pesb_pkg::UM_PORT5) & i_port_disp[5]);
			end
			pesb_pkg::EV_RES_STALL: begin
				hit = (|(i_umask & pesb_pkg::UM_STALL_ANY) & i_stall_any) // [R10]
					| (|(i_umask & pesb_pkg::UM_STALL_SCHED) & i_stall_sched) // [R11]
					| (|(i_umask & pesb_pkg::UM_STALL_SB) & i_stall_store_buf & ~i_stall_store_drain) // [R12]
					| (|(i_umask & pesb_pkg::UM_STALL_ROB) & i_stall_rob); // [R13]
			end
			pesb_pkg::EV_PEND_LOAD:
				hit = (i_umask == pesb_pkg::UM_PEND_L2) &
					(i_l2_pend_thread | (i_all_threads & i_l2_pend_other)); // [R14]
			default: hit = 1'b0;
		endcase
		if (hit)
			o_raw = one;
	end
endmodule

// file: testbench/pesb_top_props.sv
// Concurrent checks on the counter block's ports.
// Assumes one clock domain and the synchronous active-low reset of the top module.
`timescale 1ns/1ns
module pesb_top_props #(
	parameter int CNT_W = 32
) (
	input wire logic                          I_CLK,
	input wire logic                          I_RST_B,
	input wire logic                          I_AWVALID,
	input wire logic                          O_AWREADY,
	input wire logic                          I_WVALID,
	input wire logic                          O_WREADY,
	input wire logic                          O_BVALID,
	input wire logic                          I_ARVALID,
	input wire logic                          O_ARREADY,
	input wire logic                          O_RVALID,
	input wire logic                          I_RREADY,
	input wire logic [31:0]                   O_RDATA,
	input wire logic [1:0]                    O_RRESP,
	input wire logic                          I_BR_VALID,
	input wire logic [pesb_pkg::INC_W-1:0]    I_FE_EMPTY_SLOTS,
	input wire logic [pesb_pkg::PORTS-1:0]    I_PORT_DISP,
	input wire logic                          I_STALL_ANY,
	input wire logic                          I_STALL_SCHED,
	input wire logic                          I_STALL_STORE_BUF,
	input wire logic                          I_STALL_ROB,
	input wire logic                          I_L2_PEND_THREAD,
	input wire logic                          I_L2_PEND_OTHER,
	input wire logic [CNT_W-1:0]              O_COUNT,
	input wire logic                          O_OVERFLOW
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	// Any strobe that could feed some selected event
	wire ev_any = I_BR_VALID || (|I_FE_EMPTY_SLOTS) || (|I_PORT_DISP) || I_STALL_ANY || I_STALL_SCHED
		|| I_STALL_STORE_BUF || I_STALL_ROB || I_L2_PEND_THREAD || I_L2_PEND_OTHER;
	property p_count_cause; !$stable(O_COUNT) |-> $past(ev_any) || !$past(O_AWREADY); endproperty
	a_count_cause: assert property (p_count_cause) else $error("count moved without cause");
	// Only the front-end event may add more than one per cycle
	property p_count_step; $past(O_AWREADY) && $past(I_FE_EMPTY_SLOTS) == 3'd0 |-> CNT_W'(O_COUNT - $past(O_COUNT)) <= 1; endproperty
	a_count_step: assert property (p_count_step) else $error("count stepped by more than one");
	property p_ovf_wrap; $rose(O_OVERFLOW) |-> O_COUNT < $past(O_COUNT); endproperty
	a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow without wrap");
	property p_ovf_sticky; $fell(O_OVERFLOW) |-> !$past(O_AWREADY); endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow cleared without write");
	property p_b_lat; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID; endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	property p_b_block; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
	a_b_block: assert property (p_b_block) else $error("ready during write response");
	property p_r_lat; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read data late");
	property p_r_err; O_RVALID && O_RRESP == pesb_pkg::RESP_SLVERR |-> O_RDATA == 32'h0; endproperty
	a_r_err: assert property (p_r_err) else $error("error read carries data");
	property p_r_done; O_RVALID && I_RREADY |=> !O_RVALID ##1 O_ARREADY; endproperty
	a_r_done: assert property (p_r_done) else $error("read channel not freed");
	c_ovf: cover property ($rose(O_OVERFLOW));
	c_multi: cover property (CNT_W'(O_COUNT - $past(O_COUNT)) > 1);
	c_err: cover property (O_RVALID && O_RRESP == pesb_pkg::RESP_SLVERR);
endmodule

bind pesb_top pesb_top_props #(.CNT_W(CNT_W)) u_props (.*);

// file: testbench/pesb_core_model.sv
// Pipeline event source: turns a random word into one cycle of strobes.
// Assumes the bench supplies the word and a run flag each cycle.
`timescale 1ns/1ns
module pesb_core_model (
	// Clock and control
	input  wire logic        i_clk,
	input  wire logic        i_run,
	input  wire logic [31:0] i_rnd,
	// Strobes
	output logic             o_br_valid,
	output logic [5:0]       o_br_type,
	output logic             o_br_taken,
	output logic             o_br_misp,
	output logic [2:0]       o_fe_slots,
	output logic             o_be_stall,
	output logic [5:0]       o_port,
	output logic [6:0]       o_misc
);
	logic [31:0] q = 32'h0;
	logic        r = 1'b0;
	wire  [31:0] g = r ? q : 32'h0;
	always @(posedge i_clk) begin
		q <= i_rnd;
		r <= i_run;
	end
	// One branch a cycle with a one-hot type; quiet while idle
	assign o_br_valid = g[0];
	assign o_br_type  = 6'h01 << (g[3:1] % 3'd6);
	assign o_br_taken = g[4];
	assign o_br_misp  = g[5];
	assign o_fe_slots = g[8:6];
	assign o_be_stall = g[9];
	assign o_port     = g[15:10];
	assign o_misc     = g[22:16];
endmodule

// file: testbench/pesb_top_test.sv
// Self-checking bench for the branch and stall event counter.
// Assumes the pipeline model and the bound checker beside the top module.
`timescale 1ns/1ns
module pesb_top_test;
	logic        I_CLK = 1'b0;
	logic        I_RST_B = 1'b0;
	logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, bready = 1'b0, rready = 1'b0, run = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rnd = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	integer      seed = 32'hf32852eb;
	int          n_errors = 0, checks = 0;
	wire         awready, wready, bvalid, arready, rvalid, ovf, br_valid, br_taken, br_misp, be_stall;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata, count;
	wire  [5:0]  br_type, port;
	wire  [2:0]  fe_slots;
	wire  [6:0]  misc;
	logic [7:0]  s_code, s_um, s_thr;
	logic        s_edge, s_all, prev = 1'b0, hit;
	logic [2:0]  raw;
	logic [32:0] exp = 33'h0;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	// Entries are {code, unit mask, threshold, all threads, edge}
	logic [31:0] cases [28] = '{
		32'h8841_0000, 32'h8842_0000, 32'h8881_0000, 32'h8880_0000, 32'h88ff_0000,
		32'h8941_0000, 32'h89c1_0000, 32'h8984_0000, 32'h89bc_0000, 32'h89ff_0000,
		32'h9c01_0000, 32'h9c01_0200, 32'h9c01_0101, 32'h9c01_0001,
		32'ha101_0000, 32'ha102_0000, 32'ha10c_0000, 32'ha130_0000, 32'ha140_0000,
		32'ha180_0000, 32'ha104_0000, 32'ha201_0000, 32'ha204_0000, 32'ha208_0000,
		32'ha210_0000, 32'ha301_0000, 32'ha301_0002, 32'h77ff_0000};
	pesb_core_model src_u (.i_clk(I_CLK), .i_run(run), .i_rnd(rnd), .o_br_valid(br_valid), .o_br_type(br_type),
		.o_br_taken(br_taken), .o_br_misp(br_misp), .o_fe_slots(fe_slots), .o_be_stall(be_stall), .o_port(port),
		.o_misc(misc));
	pesb_top dut_u (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_AWVALID(awv), .O_AWREADY(awready), .I_AWADDR(awaddr),
		.I_WVALID(wv), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready),
		.O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
		.I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_BR_VALID(br_valid), .I_BR_TYPE(br_type),
		.I_BR_TAKEN(br_taken), .I_BR_MISP(br_misp), .I_FE_EMPTY_SLOTS(fe_slots), .I_BE_STALL(be_stall),
		.I_PORT_DISP(port), .I_STALL_ANY(misc[0]), .I_STALL_SCHED(misc[1]), .I_STALL_STORE_BUF(misc[2]),
		.I_STALL_STORE_DRAIN(misc[3]), .I_STALL_ROB(misc[4]), .I_L2_PEND_THREAD(misc[5]),
		.I_L2_PEND_OTHER(misc[6]), .O_COUNT(count), .O_OVERFLOW(ovf));
	initial forever #20 I_CLK = ~I_CLK;
	function automatic logic [2:0] ref_raw();
		logic [5:0] ports;
		ports = {s_um[7], s_um[6], |s_um[5:4], |s_um[3:2], s_um[1], s_um[0]};
		case (s_code)
		8'h88, 8'h89: return {2'b0, br_valid && (s_code == 8'h88 || br_misp) && (s_um == 8'hff
			|| ((|(br_type & s_um[5:0])) && ((s_um[7] && br_taken) || (s_um[6] && !br_taken && br_type[0]))))};
		8'h9c: return (s_um == 8'h01 && !be_stall) ? fe_slots : 3'd0;
		8'ha1: return {2'b0, |(port & ports)};
		8'ha2: return {2'b0, (s_um[0] & misc[0]) | (s_um[2] & misc[1]) | (s_um[3] & misc[2] & !misc[3]) | (s_um[4] & misc[4])};
		8'ha3: return {2'b0, s_um == 8'h01 && (misc[5] || (s_all && misc[6]))};
		default: return 3'd0;
		endcase
	endfunction
	// Reference counter, fed the same strobes the design samples
	always @(posedge I_CLK) begin
		raw = ref_raw();
		hit = raw >= ((s_thr == 8'h0) ? 8'h1 : s_thr);
		if (s_edge) exp = exp + (hit && !prev);
		else if (s_thr != 8'h0) exp = exp + hit;
		else exp = exp + raw;
		prev = hit;
	end
	always @(posedge I_CLK) begin
		if (rvalid && rready) begin
			checks++;
			if ({rresp, rdata} !== rq[0]) begin
				n_errors++;
				$display("CHECK FAILED %0t read got %h want %h", $time, {rresp, rdata}, rq[0]);
			end
			void'(rq.pop_front());
		end
		if (bvalid && bready) begin
			checks++;
			if (bresp !== bq[0]) begin
				n_errors++;
				$display("CHECK FAILED %0t write response %b", $time, bresp);
			end
			void'(bq.pop_front());
		end
	end
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		@(posedge I_CLK);
		bq.push_back(resp);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge I_CLK);
			if (awready) awv <= 1'b0;
			if (wready) wv <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [7:0] a, input logic [33:0] e);
		@(posedge I_CLK);
		rq.push_back(e);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge I_CLK);
			if (arready) arv <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask
	task automatic run_case(input logic [31:0] c, input logic [31:0] pre);
		logic [31:0] sel;
		sel = {c[15:8], 2'b01, c[1], 2'b00, c[0], 2'b00, c[23:16], c[31:24]};
		{s_code, s_um, s_thr, s_all, s_edge} = {c[31:8], c[1], c[0]};
		axi_write(8'h08, 32'h1, 2'b00);
		axi_write(8'h00, sel, 2'b00);
		axi_read(8'h00, {2'b00, sel & pesb_pkg::SEL_WMASK});
		axi_write(8'h04, pre, 2'b00);
		exp = {1'b0, pre};
		repeat (24) begin
			@(posedge I_CLK);
			rnd <= $random(seed);
			run <= 1'b1;
		end
		@(posedge I_CLK);
		run <= 1'b0;
		repeat (3) @(posedge I_CLK);
		axi_read(8'h04, {2'b00, exp[31:0]});
		axi_read(8'h08, {33'h0, exp[32]});
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{s_code, s_um, s_thr, s_all, s_edge} = 26'h0;
		repeat (3) @(posedge I_CLK);
		I_RST_B <= 1'b1;
		@(posedge I_CLK);
		axi_read(8'h00, 34'h0);
		axi_read(8'h04, 34'h0);
		axi_read(8'h08, 34'h0);
		axi_read(8'h0c, {2'b10, 32'h0});
		axi_write(8'h0c, 32'hffffffff, 2'b10);
		axi_read(8'h00, 34'h0);
		foreach (cases[i]) run_case(cases[i], 32'h0);
		run_case(32'ha201_0000, 32'hfffffffe);
		axi_write(8'h08, 32'h1, 2'b00);
		axi_read(8'h08, 34'h0);
		wstrb <= 4'h2;
		axi_write(8'h04, 32'h0000_5a00, 2'b00);
		wstrb <= 4'hf;
		axi_read(8'h04, {2'b00, exp[31:16], 8'h5a, exp[7:0]});
		tally_and_finish();
	end
	initial begin
		#400000;
		n_errors++;
		tally_and_finish();
	end
endmodule
